// file: ohp_pkg.sv
// Package of constants and types for the overhead terminator host port
package ohp_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RX_K1 = 8'h00;
  localparam logic [7:0] ADDR_RX_K2 = 8'h01;
  localparam logic [7:0] ADDR_PROT_K1 = 8'h02;
  localparam logic [7:0] ADDR_PROT_K2 = 8'h03;
  localparam logic [7:0] ADDR_B1_LOW = 8'h45;
  localparam logic [7:0] ADDR_B1_HIGH = 8'h46;
  localparam logic [7:0] ADDR_OPCFG1 = 8'h50;
  localparam logic [7:0] ADDR_BUF_ALL = 8'h54;
  localparam logic [7:0] ADDR_SECT_IRQ = 8'ha0;
  localparam logic [7:0] ADDR_BYTE_IRQ = 8'ha1;
  localparam logic [7:0] ADDR_SECT_IEN = 8'hb0;
  localparam logic [7:0] ADDR_BYTE_IEN = 8'hb1;
  localparam logic [7:0] ADDR_SECT_STAT = 8'hc0;

  // Field positions
  localparam int BIT_OOF = 0;
  localparam int BIT_LOF = 1;
  localparam int BIT_B1_OVF = 7;
  localparam int BIT_K1_CHG = 0;
  localparam int BIT_K2_CHG = 1;
  localparam int BIT_PK1_CHG = 2;
  localparam int BIT_PK2_CHG = 3;
  localparam int BIT_ALARM_HOLD = 0;
  localparam int BIT_BYTE_HOLD = 1;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Byte clock period and host access spacing
  localparam int BYTE_CLK_PERIOD_PS = 51440;
  localparam int CORE_CLK_PERIOD_PS = 100000;
  localparam int ACCESS_SPACING_PS = 4 * BYTE_CLK_PERIOD_PS;
  localparam int ACCESS_SPACING_CYC_RAW =
    (ACCESS_SPACING_PS + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;
  localparam int ACCESS_SPACING_CYC =
    (ACCESS_SPACING_CYC_RAW < 1) ? 1 : ACCESS_SPACING_CYC_RAW;
  localparam int SYNC_STAGES = 2;

  // Host pin group, sampled together
  typedef struct packed {
    logic cs_n;
    logic wr_rw;
    logic rd_e;
    logic als;
  } ohp_strobe_type;

  // Overhead byte arriving from the receive side
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } ohp_byte_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } ohp_state_type;

endpackage

// file: ohp_sync.sv
// Two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module ohp_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("ohp_sync needs a width of at least one");
  end

  // First stage feeds the second stage only
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// file: ohp_host_port.sv
// Asynchronous host port with interrupt, byte hold and counter buffering
`timescale 1ns/1ps
module ohp_host_port #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic host_style_select_i,
  input wire logic cs_n_i,
  input wire logic wr_rw_i,
  input wire logic rd_e_i,
  input wire logic address_latch_strobe_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic irq_o,
  input wire logic out_of_frame_state_i,
  input wire logic loss_of_frame_state_i,
  input wire ohp_pkg::ohp_byte_type rx_k1_i,
  input wire ohp_pkg::ohp_byte_type rx_k2_i,
  input wire ohp_pkg::ohp_byte_type prot_k1_i,
  input wire ohp_pkg::ohp_byte_type prot_k2_i,
  input wire logic prot_master_i,
  input wire logic b1_error_i
);

  if (COUNT_WIDTH != 16) begin : g_bad_count
    $error("B1 counter spans exactly two byte registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe synchronisation and decode

  ohp_pkg::ohp_strobe_type raw_strobe;
  ohp_pkg::ohp_strobe_type sync_strobe;
  ohp_pkg::ohp_state_type state_r;
  ohp_pkg::ohp_state_type state_nxt;
  logic read_req;
  logic write_req;
  logic als_raw_r;
  logic [7:0] latched_addr_r;
  logic [7:0] access_addr_r;
  logic [7:0] write_data_r;
  logic read_start;
  logic write_done;
  logic [7:0] start_addr;
  logic [7:0] cur_addr;
  logic write_pins;

  assign raw_strobe = '{cs_n: cs_n_i, wr_rw: wr_rw_i, rd_e: rd_e_i,
                        als: address_latch_strobe_i};

  assign start_addr = sync_strobe.als ? addr_i : latched_addr_r;
  // Reads decode in their start cycle, before access_addr_r has caught up
  assign cur_addr = (state_r == ohp_pkg::ST_IDLE) ? start_addr : access_addr_r;
  assign write_pins = !cs_n_i && !wr_rw_i &&
                      (host_style_select_i ? !rd_e_i : rd_e_i);

  ohp_sync #(
    .WIDTH(4),
    .RESET_VAL(4'hf)
  ) u_strobe_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(raw_strobe),
    .q_o(sync_strobe)
  );

  always_comb begin
    if (!host_style_select_i) begin
      // Separate strobes: the idle one must stay high
      read_req = !sync_strobe.cs_n && !sync_strobe.rd_e && sync_strobe.wr_rw;
      write_req = !sync_strobe.cs_n && !sync_strobe.wr_rw && sync_strobe.rd_e;
    end else begin
      // Enable low starts the cycle, direction picks read or write
      read_req = !sync_strobe.cs_n && !sync_strobe.rd_e && sync_strobe.wr_rw;
      write_req = !sync_strobe.cs_n && !sync_strobe.rd_e && !sync_strobe.wr_rw;
    end
  end

  // Address latch is a raw-pin falling edge; with the strobe tied high the
  // address pins are used directly
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      als_raw_r <= 1'b1;
      latched_addr_r <= ohp_pkg::RESET_BYTE;
    end else begin
      als_raw_r <= address_latch_strobe_i;
      if (als_raw_r && !address_latch_strobe_i) begin
        latched_addr_r <= addr_i;
      end
    end
  end

  // One access per strobe: the state must return to idle before another
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ohp_pkg::ST_IDLE: begin
        if (read_req) begin
          state_nxt = ohp_pkg::ST_READ;
        end else if (write_req) begin
          state_nxt = ohp_pkg::ST_WRITE;
        end
      end
      ohp_pkg::ST_READ: begin
        if (!read_req) begin
          state_nxt = ohp_pkg::ST_IDLE;
        end
      end
      ohp_pkg::ST_WRITE: begin
        if (!write_req) begin
          state_nxt = ohp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = ohp_pkg::ST_IDLE;
      end
    endcase
  end

  assign read_start = (state_r == ohp_pkg::ST_IDLE) && read_req;
  // Write data is taken at the end of the strobe, where it is valid
  assign write_done = (state_r == ohp_pkg::ST_WRITE) && !write_req;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ohp_pkg::ST_IDLE;
      access_addr_r <= ohp_pkg::RESET_BYTE;
      write_data_r <= ohp_pkg::RESET_BYTE;
    end else begin
      state_r <= state_nxt;
      if (state_r == ohp_pkg::ST_IDLE && (read_req || write_req)) begin
        access_addr_r <= start_addr;
      end
      // Data stands only while the pins show a write; the synchronised view
      // lags two cycles, past the host's data hold
      if (write_pins) begin
        write_data_r <= data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] sect_status_r;
  logic [7:0] sect_irq_r;
  logic [7:0] byte_irq_r;
  logic [7:0] sect_ien_r;
  logic [7:0] byte_ien_r;
  logic [7:0] opcfg1_r;
  logic [7:0] byte_reg_r [4];
  logic [15:0] b1_count_r;
  logic [15:0] b1_buffer_r;
  logic alarm_hold;
  logic byte_hold;
  logic rd_status;
  logic buffer_b1;
  logic [7:0] status_now;
  logic [7:0] read_value;
  ohp_pkg::ohp_byte_type byte_in [4];

  assign alarm_hold = opcfg1_r[ohp_pkg::BIT_ALARM_HOLD];
  assign byte_hold = opcfg1_r[ohp_pkg::BIT_BYTE_HOLD];
  assign rd_status = read_start && cur_addr == ohp_pkg::ADDR_SECT_STAT;
  assign buffer_b1 = write_done && (access_addr_r == ohp_pkg::ADDR_B1_HIGH ||
                                    access_addr_r == ohp_pkg::ADDR_BUF_ALL);

  always_comb begin
    status_now = sect_status_r;
    status_now[ohp_pkg::BIT_OOF] = out_of_frame_state_i;
    status_now[ohp_pkg::BIT_LOF] = loss_of_frame_state_i;
  end

  // Host-written configuration and enables
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      opcfg1_r <= ohp_pkg::RESET_BYTE;
      sect_ien_r <= ohp_pkg::RESET_BYTE;
      byte_ien_r <= ohp_pkg::RESET_BYTE;
    end else if (write_done) begin
      case (access_addr_r)
        ohp_pkg::ADDR_OPCFG1: opcfg1_r <= write_data_r;
        ohp_pkg::ADDR_SECT_IEN: sect_ien_r <= write_data_r;
        ohp_pkg::ADDR_BYTE_IEN: byte_ien_r <= write_data_r;
        default: begin
        end
      endcase
    end
  end

  // Status follows its condition; change sets the flag, status read clears
  // it, and a change in the clearing cycle keeps the flag set
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sect_status_r <= ohp_pkg::RESET_BYTE;
      sect_irq_r <= ohp_pkg::RESET_BYTE;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if ((i == ohp_pkg::BIT_OOF || i == ohp_pkg::BIT_LOF) && !alarm_hold &&
            status_now[i] != sect_status_r[i]) begin
          sect_irq_r[i] <= 1'b1;
        end else if (i == ohp_pkg::BIT_B1_OVF && !alarm_hold &&
                     b1_error_i && b1_count_r == ohp_pkg::COUNT_MAX &&
                     !buffer_b1) begin
          sect_irq_r[i] <= 1'b1;
        end else if (i == ohp_pkg::BIT_B1_OVF && buffer_b1) begin
          sect_irq_r[i] <= 1'b0;
        end else if (i != ohp_pkg::BIT_B1_OVF && rd_status) begin
          sect_irq_r[i] <= 1'b0;
        end
      end
      if (!alarm_hold) begin
        sect_status_r <= status_now;
      end
    end
  end

  // Overhead bytes: received K1 and K2, then protection K1 and K2
  assign byte_in[0] = rx_k1_i;
  assign byte_in[1] = rx_k2_i;
  assign byte_in[2] = '{valid: prot_k1_i.valid && prot_master_i, value: prot_k1_i.value};
  assign byte_in[3] = '{valid: prot_k2_i.valid && prot_master_i, value: prot_k2_i.value};

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_irq_r <= ohp_pkg::RESET_BYTE;
      for (int i = 0; i < 4; i++) begin
        byte_reg_r[i] <= ohp_pkg::RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        // A held byte stays frozen until the host has read it
        if (byte_in[i].valid && byte_in[i].value != byte_reg_r[i] &&
            !(byte_hold && byte_irq_r[i])) begin
          byte_reg_r[i] <= byte_in[i].value;
          byte_irq_r[i] <= 1'b1;
        end else if (read_start && cur_addr == 8'(i)) begin
          byte_irq_r[i] <= 1'b0;
        end
      end
    end
  end

  // B1 counter wraps on overflow; buffering snapshots and restarts it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      b1_count_r <= ohp_pkg::RESET_COUNT;
      b1_buffer_r <= ohp_pkg::RESET_COUNT;
    end else if (buffer_b1) begin
      b1_buffer_r <= b1_count_r;
      b1_count_r <= {15'h0000, b1_error_i};
    end else if (b1_error_i) begin
      b1_count_r <= b1_count_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and interrupt output

  always_comb begin
    read_value = ohp_pkg::RESET_BYTE;
    case (cur_addr)
      ohp_pkg::ADDR_RX_K1: read_value = byte_reg_r[0];
      ohp_pkg::ADDR_RX_K2: read_value = byte_reg_r[1];
      ohp_pkg::ADDR_PROT_K1: read_value = byte_reg_r[2];
      ohp_pkg::ADDR_PROT_K2: read_value = byte_reg_r[3];
      // Both bytes come from the one snapshot, so order does not matter
      ohp_pkg::ADDR_B1_LOW: read_value = b1_buffer_r[7:0];
      ohp_pkg::ADDR_B1_HIGH: read_value = b1_buffer_r[15:8];
      ohp_pkg::ADDR_OPCFG1: read_value = opcfg1_r;
      ohp_pkg::ADDR_SECT_IRQ: read_value = sect_irq_r;
      ohp_pkg::ADDR_BYTE_IRQ: read_value = byte_irq_r;
      ohp_pkg::ADDR_SECT_IEN: read_value = sect_ien_r;
      ohp_pkg::ADDR_BYTE_IEN: read_value = byte_ien_r;
      ohp_pkg::ADDR_SECT_STAT: read_value = sect_status_r;
      default: read_value = ohp_pkg::RESET_BYTE;
    endcase
  end

  // Read data is captured once per access, before the clear-on-read lands
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o <= ohp_pkg::RESET_BYTE;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= read_req && state_r != ohp_pkg::ST_WRITE;
      if (state_r == ohp_pkg::ST_READ && read_req &&
          state_r != state_nxt) begin
        data_o <= data_o;
      end else if (read_start) begin
        data_o <= read_value;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sect_irq_r & sect_ien_r) || |(byte_irq_r & byte_ien_r);
    end
  end

endmodule

// file: ohp_host_port_props.sv
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module ohp_host_port_props #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic wr_rw_i,
  input wire logic rd_e_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_oe_cause: assert property (
    $rose(data_oe_o) |-> $past(!cs_n_i && !rd_e_i && wr_rw_i, 2)
  ) else $error("data driven without a read strobe");
  a_oe_latency: assert property (
    (!cs_n_i && !rd_e_i && wr_rw_i) [*4] |-> data_oe_o
  ) else $error("read strobe not answered in time");
  a_oe_holds: assert property (
    data_oe_o && !rd_e_i && $past(!rd_e_i) |=> data_oe_o
  ) else $error("data released while read strobe held");
  a_oe_release: assert property (
    $rose(rd_e_i) |-> ##[1:4] !data_oe_o
  ) else $error("data still driven after read ended");
  a_data_steady: assert property (
    data_oe_o && $past(data_oe_o) |-> $stable(data_o)
  ) else $error("read data changed during a read");
  a_write_quiet: assert property (
    !wr_rw_i [*4] |-> !data_oe_o
  ) else $error("data driven during a write");
  a_idle_quiet: assert property (
    cs_n_i [*5] |-> !data_oe_o
  ) else $error("data driven while not selected");
  a_reset_quiet: assert property (
    $fell(reset_i) |-> !irq_o && !data_oe_o && data_o == 8'h00
  ) else $error("outputs not idle after reset");
endmodule

bind ohp_host_port ohp_host_port_props #(.COUNT_WIDTH(COUNT_WIDTH)) u_props (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .cs_n_i(cs_n_i),
  .wr_rw_i(wr_rw_i),
  .rd_e_i(rd_e_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .irq_o(irq_o)
);

// file: ohp_host_model.sv
// Host microprocessor model for the asynchronous register port
`timescale 1ns/1ps
module ohp_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic data_oe_i,
  output logic style_o,
  output logic cs_n_o,
  output logic wr_rw_o,
  output logic rd_e_o,
  output logic als_o,
  output logic [7:0] addr_o,
  output logic [7:0] data_o
);
  logic mux_r;

  initial begin
    style_o = 1'b0;
    cs_n_o = 1'b1;
    wr_rw_o = 1'b1;
    rd_e_o = 1'b1;
    als_o = 1'b1;
    addr_o = 8'h00;
    data_o = 8'hff;
    mux_r = 1'b0;
  end

  task set_mode(input logic s, input logic m);
    @(posedge core_clk_i);
    style_o <= s;
    mux_r <= m;
  endtask

  // Muxed bus: address latched on the strobe fall, then the pins move on
  task head(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_o <= a;
    if (mux_r) begin
      @(posedge core_clk_i);
      als_o <= 1'b0;
      @(posedge core_clk_i);
      addr_o <= ~a;
    end
  endtask

  // Released lines show the inverse so a stale value never reads as good
  task tail;
    cs_n_o <= 1'b1;
    rd_e_o <= 1'b1;
    wr_rw_o <= 1'b1;
    als_o <= 1'b1;
    data_o <= ~data_o;
    addr_o <= ~addr_o;
    repeat (6) @(posedge core_clk_i);
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    head(a);
    cs_n_o <= 1'b0;
    rd_e_o <= 1'b0;
    wr_rw_o <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (data_oe_i !== 1'b1 && n < 20);
    d = rd_data_i;
    tail();
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    head(a);
    cs_n_o <= 1'b0;
    wr_rw_o <= 1'b0;
    rd_e_o <= ~style_o;
    data_o <= d;
    repeat (4) @(posedge core_clk_i);
    tail();
  endtask
endmodule

// file: ohp_host_port_tb.sv
// Self-checking testbench for the host port
`timescale 1ns/1ps
module ohp_host_port_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic oof = 1'b0;
  logic lof = 1'b0;
  logic pmaster = 1'b0;
  logic b1_err = 1'b0;
  ohp_pkg::ohp_byte_type byt [4];
  wire logic style, cs_n, wr_rw, rd_e, als, oe, irq;
  wire logic [7:0] addr, wdata, rdata;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] got;

  always #50 clk = ~clk;

  ohp_host_model host_u (.core_clk_i(clk), .rd_data_i(rdata), .data_oe_i(oe),
    .style_o(style), .cs_n_o(cs_n), .wr_rw_o(wr_rw), .rd_e_o(rd_e), .als_o(als),
    .addr_o(addr), .data_o(wdata));

  ohp_host_port dut_u (.core_clk_i(clk), .reset_i(reset), .host_style_select_i(style),
    .cs_n_i(cs_n), .wr_rw_i(wr_rw), .rd_e_i(rd_e), .address_latch_strobe_i(als),
    .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .irq_o(irq),
    .out_of_frame_state_i(oof), .loss_of_frame_state_i(lof), .rx_k1_i(byt[0]),
    .rx_k2_i(byt[1]), .prot_k1_i(byt[2]), .prot_k2_i(byt[3]),
    .prot_master_i(pmaster), .b1_error_i(b1_err));

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, got);
    check(name, got, exp);
  endtask

  task put(input int w, input logic [7:0] v);
    @(posedge clk);
    byt[w] <= '{valid: 1'b1, value: v};
    @(posedge clk);
    byt[w].valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task errs(input int n);
    @(posedge clk);
    b1_err <= 1'b1;
    repeat (n) @(posedge clk);
    b1_err <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task t_reset;
    rdc("k1", ohp_pkg::ADDR_RX_K1, ohp_pkg::RESET_BYTE);
    rdc("sect flags", ohp_pkg::ADDR_SECT_IRQ, 8'h00);
    rdc("status", ohp_pkg::ADDR_SECT_STAT, 8'h00);
    host_u.wr(ohp_pkg::ADDR_RX_K1, 8'ha5);
    rdc("k1 read only", ohp_pkg::ADDR_RX_K1, 8'h00);
    rdc("unmapped", 8'h7f, 8'h00);
    $display("test reset done");
  endtask

  task t_status;
    @(posedge clk) oof <= 1'b1;
    repeat (4) @(posedge clk);
    check("irq masked", {7'h00, irq}, 8'h00);
    rdc("oof flag", ohp_pkg::ADDR_SECT_IRQ, 8'h01);
    @(posedge clk) oof <= 1'b0;
    repeat (4) @(posedge clk) oof <= 1'b1;
    rdc("oof kept", ohp_pkg::ADDR_SECT_IRQ, 8'h01);
    rdc("oof status", ohp_pkg::ADDR_SECT_STAT, 8'h01);
    rdc("oof clear", ohp_pkg::ADDR_SECT_IRQ, 8'h00);
    host_u.wr(ohp_pkg::ADDR_SECT_IEN, 8'h01);
    @(posedge clk) oof <= 1'b0;
    repeat (4) @(posedge clk);
    check("irq on", {7'h00, irq}, 8'h01);
    rdc("oof status low", ohp_pkg::ADDR_SECT_STAT, 8'h00);
    check("irq off", {7'h00, irq}, 8'h00);
    $display("test status done");
  endtask

  task t_hold;
    host_u.wr(ohp_pkg::ADDR_OPCFG1, 8'h01);
    @(posedge clk) lof <= 1'b1;
    repeat (4) @(posedge clk);
    rdc("held flags", ohp_pkg::ADDR_SECT_IRQ, 8'h00);
    rdc("held status", ohp_pkg::ADDR_SECT_STAT, 8'h00);
    host_u.wr(ohp_pkg::ADDR_OPCFG1, 8'h00);
    rdc("lof flag", ohp_pkg::ADDR_SECT_IRQ, 8'h02);
    rdc("lof status", ohp_pkg::ADDR_SECT_STAT, 8'h02);
    $display("test hold done");
  endtask

  task t_byte;
    put(0, 8'h5a);
    rdc("k1 flag", ohp_pkg::ADDR_BYTE_IRQ, 8'h01);
    host_u.wr(ohp_pkg::ADDR_BYTE_IEN, 8'h01);
    check("irq byte", {7'h00, irq}, 8'h01);
    rdc("k1 value", ohp_pkg::ADDR_RX_K1, 8'h5a);
    rdc("k1 clear", ohp_pkg::ADDR_BYTE_IRQ, 8'h00);
    check("irq byte off", {7'h00, irq}, 8'h00);
    put(1, 8'h77);
    rdc("k2 value", ohp_pkg::ADDR_RX_K2, 8'h77);
    host_u.wr(ohp_pkg::ADDR_OPCFG1, 8'h02);
    put(0, 8'h11);
    put(0, 8'h22);
    rdc("k1 frozen", ohp_pkg::ADDR_RX_K1, 8'h11);
    put(0, 8'h33);
    rdc("k1 freed", ohp_pkg::ADDR_RX_K1, 8'h33);
    @(posedge clk) pmaster <= 1'b1;
    put(2, 8'h44);
    put(2, 8'h55);
    rdc("pk1 frozen", ohp_pkg::ADDR_PROT_K1, 8'h44);
    put(3, 8'h66);
    rdc("pk2", ohp_pkg::ADDR_PROT_K2, 8'h66);
    host_u.wr(ohp_pkg::ADDR_BYTE_IEN, 8'h00);
    $display("test bytes done");
  endtask

  task t_count;
    errs(3);
    host_u.wr(ohp_pkg::ADDR_B1_HIGH, 8'h00);
    rdc("b1 low", ohp_pkg::ADDR_B1_LOW, 8'h03);
    errs(2);
    rdc("b1 high", ohp_pkg::ADDR_B1_HIGH, 8'h00);
    rdc("b1 low kept", ohp_pkg::ADDR_B1_LOW, 8'h03);
    host_u.wr(ohp_pkg::ADDR_BUF_ALL, 8'h00);
    rdc("b1 all low", ohp_pkg::ADDR_B1_LOW, 8'h02);
    host_u.wr(ohp_pkg::ADDR_SECT_IEN, 8'h80);
    errs(65538);
    rdc("ovf flag", ohp_pkg::ADDR_SECT_IRQ, 8'h80);
    check("irq ovf", {7'h00, irq}, 8'h01);
    host_u.wr(ohp_pkg::ADDR_B1_HIGH, 8'h00);
    check("irq ovf off", {7'h00, irq}, 8'h00);
    rdc("ovf clear", ohp_pkg::ADDR_SECT_IRQ, 8'h00);
    rdc("b1 wrapped", ohp_pkg::ADDR_B1_LOW, 8'h02);
    $display("test counter done");
  endtask

  task t_modes;
    for (int i = 0; i < 4; i++) begin
      host_u.set_mode(i[0], i[1]);
      host_u.wr(ohp_pkg::ADDR_BYTE_IEN, 8'h10 + 8'(i));
      rdc("mode", ohp_pkg::ADDR_BYTE_IEN, 8'h10 + 8'(i));
    end
    $display("test modes done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Ceiling covers the long overflow run plus the short tests
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    for (int w = 0; w < 4; w++) byt[w] = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_status();
    t_hold();
    t_byte();
    t_count();
    t_modes();
    close_out();
  end
endmodule
